// ===== design/vlan_acl_pkg.sv
// Constants, register map and entry layouts for the VLAN and rule table access block.
// Assumes one switch clock and a plain register port with one-cycle strobes.
package vlan_acl_pkg;
	localparam int NUM_PORTS    = 7;
	localparam int VLAN_ENTRIES = 4096;
	localparam int ACL_ENTRIES  = 16;
	localparam int ACL_BYTES    = 16;
	localparam int ADDR_W       = 16;

	// Global VLAN access registers
	localparam logic [15:0] VLAN_ENTRY0_ADDR = 16'h0400;
	localparam logic [15:0] VLAN_ENTRY1_ADDR = 16'h0404;
	localparam logic [15:0] VLAN_ENTRY2_ADDR = 16'h0408;
	localparam logic [15:0] VLAN_INDEX_ADDR  = 16'h040C;
	localparam logic [15:0] VLAN_CTRL_ADDR   = 16'h040E;
	// Per port window 0xN6xx, port number in bits 15:12
	localparam logic [7:0]  ACL_WIN_PAGE     = 8'h06;
	localparam logic [7:0]  ACL_BEN_MSB_OFS  = 8'h10;
	localparam logic [7:0]  ACL_BEN_LSB_OFS  = 8'h11;
	localparam logic [7:0]  ACL_CTRL_OFS     = 8'h12;

	localparam int VLAN_START_BIT = 7;
	localparam int VLAN_READ_BIT  = 0;
	localparam int ACL_WRITE_BIT  = 4;
	localparam int ACL_RD_DONE_BIT = 5;
	localparam int ACL_WR_DONE_BIT = 6;
	localparam int ACL_UNUSED_BYTE = 12;
	localparam int ACL_UNUSED_BEN  = 3;
	localparam int VLAN_OP_CYCLES = 2;
	localparam logic [15:0] BEN_RESET = 16'h0000;

	typedef struct packed {
		logic       valid;              // 31
		logic       use_member_list;    // 30
		logic [2:0] priority_val;       // 29:27
		logic [2:0] spanning_tree_group;// 26:24
		logic [6:0] filter_group;       // 6:0 of entry 0
		logic [6:0] untag_mask;         // entry 1
		logic [6:0] member_mask;        // entry 2
	} vlan_entry_t;

	typedef enum {VLAN_IDLE, VLAN_BUSY} vlan_state_t;
endpackage : vlan_acl_pkg

// ===== design/vlan_acl_table_access.sv
// VLAN table and per-port rule table indirect access logic.
// Assumes register master obeys one-cycle strobes and waits for completion.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module vlan_acl_table_access (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	input  wire logic [11:0] lookup_vid_in,
	output logic      [31:0] rdata_out,
	output logic             lookup_valid_out,
	output logic      [6:0]  lookup_fwd_mask_out,
	output logic      [6:0]  lookup_untag_out,
	output logic      [2:0]  lookup_prio_out,
	output logic      [6:0]  lookup_filter_out
);
	localparam int NP = vlan_acl_pkg::NUM_PORTS;
	localparam int NB = vlan_acl_pkg::ACL_BYTES;

	// VLAN table storage
	vlan_acl_pkg::vlan_entry_t vlan_mem [vlan_acl_pkg::VLAN_ENTRIES];
	vlan_acl_pkg::vlan_entry_t stage;
	vlan_acl_pkg::vlan_entry_t next_stage;
	logic [11:0] vindex;
	logic [11:0] next_vindex;
	logic        vread;
	logic        next_vread;
	vlan_acl_pkg::vlan_state_t vstate;
	vlan_acl_pkg::vlan_state_t next_vstate;
	logic [1:0]  vcnt;
	logic [1:0]  next_vcnt;
	logic        vmem_we;
	vlan_acl_pkg::vlan_entry_t vmem_rd;

	// Rule tables: one array per port, declared inside the port loop
	logic [7:0]  abyte [NP][NB];
	logic [7:0]  next_abyte [NP][NB];
	logic [15:0] aben [NP];
	logic [15:0] next_aben [NP];
	logic [3:0]  aidx [NP];
	logic [3:0]  next_aidx [NP];
	logic [NP-1:0] ard_done;
	logic [NP-1:0] next_ard_done;
	logic [NP-1:0] awr_done;
	logic [NP-1:0] next_awr_done;
	logic [NP-1:0] ard_pend;
	logic [NP-1:0] next_ard_pend;
	logic [31:0] next_rdata;

	logic [3:0]  port_sel;
	logic        in_win;
	logic [7:0]  wofs;
	assign port_sel = addr_in[15:12] - 4'h1;
	assign in_win = (addr_in[11:8] == vlan_acl_pkg::ACL_WIN_PAGE[3:0]) &&
		(addr_in[15:12] != 4'h0) && (addr_in[15:12] <= 4'(NP));
	assign wofs = addr_in[7:0];

	// VLAN control sequencing
	always_comb begin
		next_stage  = stage;
		next_vindex = vindex;
		next_vread  = vread;
		next_vstate = vstate;
		next_vcnt   = vcnt;
		vmem_we     = 1'b0;
		if (wr_in && vstate == vlan_acl_pkg::VLAN_IDLE) begin
			case (addr_in)
				vlan_acl_pkg::VLAN_ENTRY0_ADDR: begin
					next_stage.valid = wdata_in[31];
					next_stage.use_member_list = wdata_in[30];
					next_stage.priority_val = wdata_in[29:27];
					next_stage.spanning_tree_group = wdata_in[26:24];
					next_stage.filter_group = wdata_in[6:0];
				end
				vlan_acl_pkg::VLAN_ENTRY1_ADDR: next_stage.untag_mask = wdata_in[6:0];
				vlan_acl_pkg::VLAN_ENTRY2_ADDR: next_stage.member_mask = wdata_in[6:0];
				vlan_acl_pkg::VLAN_INDEX_ADDR:  next_vindex = wdata_in[11:0];
				vlan_acl_pkg::VLAN_CTRL_ADDR: begin
					if (wdata_in[vlan_acl_pkg::VLAN_START_BIT]) begin
						next_vread  = wdata_in[vlan_acl_pkg::VLAN_READ_BIT];
						next_vstate = vlan_acl_pkg::VLAN_BUSY;
						next_vcnt   = 2'(vlan_acl_pkg::VLAN_OP_CYCLES - 1);
					end
				end
				default: ;
			endcase
		end
		case (vstate)
			vlan_acl_pkg::VLAN_BUSY: begin
				if (vcnt == 2'h0) begin
					next_vstate = vlan_acl_pkg::VLAN_IDLE;
					if (vread) begin
						next_stage = vmem_rd;
					end else begin
						vmem_we = 1'b1;
					end
				end else begin
					next_vcnt = vcnt - 2'h1;
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stage  <= '0;
			vindex <= 12'h000;
			vread  <= 1'b0;
			vstate <= vlan_acl_pkg::VLAN_IDLE;
			vcnt   <= 2'h0;
		end else begin
			stage  <= next_stage;
			vindex <= next_vindex;
			vread  <= next_vread;
			vstate <= next_vstate;
			vcnt   <= next_vcnt;
		end
	end

	// Memory ports; table has no reset, software fills it before lookup use
	always_ff @(posedge clk_in) begin
		if (vmem_we) begin
			vlan_mem[vindex] <= stage;
		end
		vmem_rd <= vlan_mem[vindex];
	end

	// Lookup side port, registered outputs
	vlan_acl_pkg::vlan_entry_t look;
	logic        next_lookup_valid;
	logic [6:0]  next_lookup_fwd_mask;
	logic [6:0]  next_lookup_untag;
	logic [2:0]  next_lookup_prio;
	logic [6:0]  next_lookup_filter;
	always_ff @(posedge clk_in) begin
		look <= vlan_mem[lookup_vid_in];
	end
	always_comb begin
		next_lookup_valid    = look.valid;
		// Clear option leaves forwarding to the other scheme
		// Invalid entry forwards nowhere, whatever its option bit says
		next_lookup_fwd_mask = (look.valid && look.use_member_list) ?
			look.member_mask : 7'h00;
		next_lookup_untag    = look.untag_mask;
		next_lookup_prio     = look.priority_val;
		next_lookup_filter   = look.filter_group;
	end
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lookup_valid_out    <= 1'b0;
			lookup_fwd_mask_out <= 7'h00;
			lookup_untag_out    <= 7'h00;
			lookup_prio_out     <= 3'h0;
			lookup_filter_out   <= 7'h00;
		end else begin
			lookup_valid_out    <= next_lookup_valid;
			lookup_fwd_mask_out <= next_lookup_fwd_mask;
			lookup_untag_out    <= next_lookup_untag;
			lookup_prio_out     <= next_lookup_prio;
			lookup_filter_out   <= next_lookup_filter;
		end
	end

	// Rule table access per port
	logic [NP-1:0] ctrl_wr;
	logic [NP-1:0] acl_do_wr;
	generate
		for (genvar p = 0; p < NP; p++) begin : g_port
			// Own array per port, so each table has a single writing process
			logic [7:0] rule_mem [vlan_acl_pkg::ACL_ENTRIES*NB];
			assign ctrl_wr[p] = wr_in && in_win && port_sel == 4'(p) &&
				wofs == vlan_acl_pkg::ACL_CTRL_OFS;
			assign acl_do_wr[p] = ctrl_wr[p] && wdata_in[vlan_acl_pkg::ACL_WRITE_BIT];
			always_comb begin
				next_abyte[p]    = abyte[p];
				next_aben[p]     = aben[p];
				next_aidx[p]     = aidx[p];
				next_ard_pend[p] = 1'b0;
				next_ard_done[p] = ard_done[p];
				next_awr_done[p] = awr_done[p];
				if (wr_in && in_win && port_sel == 4'(p)) begin
					if (wofs < 8'(NB)) begin
						next_abyte[p][wofs[3:0]] = wdata_in[7:0];
					end
					if (wofs == vlan_acl_pkg::ACL_BEN_MSB_OFS) begin
						next_aben[p][15:8] = wdata_in[7:0];
					end
					if (wofs == vlan_acl_pkg::ACL_BEN_LSB_OFS) begin
						next_aben[p][7:0] = wdata_in[7:0];
					end
				end
				if (ctrl_wr[p]) begin
					next_aidx[p] = wdata_in[3:0];
					if (wdata_in[vlan_acl_pkg::ACL_WRITE_BIT]) begin
						next_awr_done[p] = 1'b1;
					end else begin
						next_ard_pend[p] = 1'b1;
						next_ard_done[p] = 1'b0;
					end
				end
				if (ard_pend[p]) begin
					for (int b = 0; b < NB; b++) begin
						// Reversed enables: byte b gated by bit 15-b
						if (aben[p][15-b] && b != vlan_acl_pkg::ACL_UNUSED_BYTE) begin
							next_abyte[p][b] = rule_mem[int'(aidx[p])*NB+b];
						end
					end
					next_ard_done[p] = 1'b1;
				end
			end
			always_ff @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					for (int b = 0; b < NB; b++) begin
						abyte[p][b] <= 8'h00;
					end
					aben[p]     <= vlan_acl_pkg::BEN_RESET;
					aidx[p]     <= 4'h0;
					ard_pend[p] <= 1'b0;
					ard_done[p] <= 1'b1;
					awr_done[p] <= 1'b1;
				end else begin
					abyte[p]    <= next_abyte[p];
					aben[p]     <= next_aben[p];
					aidx[p]     <= next_aidx[p];
					ard_pend[p] <= next_ard_pend[p];
					ard_done[p] <= next_ard_done[p];
					awr_done[p] <= next_awr_done[p];
				end
			end
			// Byte-masked write into the rule table, one cycle
			always_ff @(posedge clk_in) begin
				if (acl_do_wr[p]) begin
					for (int b = 0; b < NB; b++) begin
						if (aben[p][15-b] && b != vlan_acl_pkg::ACL_UNUSED_BYTE) begin
							rule_mem[int'(wdata_in[3:0])*NB+b] <= abyte[p][b];
						end
					end
				end
			end
		end
	endgenerate

	// Read mux, data one cycle after strobe
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (rd_in) begin
			case (addr_in)
				vlan_acl_pkg::VLAN_ENTRY0_ADDR: next_rdata = {stage.valid,
					stage.use_member_list, stage.priority_val, stage.spanning_tree_group,
					17'h0_0000, stage.filter_group};
				vlan_acl_pkg::VLAN_ENTRY1_ADDR: next_rdata = {25'h000_0000, stage.untag_mask};
				vlan_acl_pkg::VLAN_ENTRY2_ADDR: next_rdata = {25'h000_0000, stage.member_mask};
				vlan_acl_pkg::VLAN_INDEX_ADDR:  next_rdata = {20'h0_0000, vindex};
				vlan_acl_pkg::VLAN_CTRL_ADDR:   next_rdata = {24'h00_0000,
					vstate == vlan_acl_pkg::VLAN_BUSY, 6'h00, vread};
				default: begin
					if (in_win && port_sel < 4'(NP)) begin
						if (wofs < 8'(NB)) begin
							next_rdata = {24'h00_0000, abyte[port_sel[2:0]][wofs[3:0]]};
							if (wofs == 8'h00) begin
								next_rdata[7:4] = 4'h0;
							end
							if (wofs == 8'h0B) begin
								next_rdata[4:0] = 5'h00;
							end
							if (wofs == 8'h0C) begin
								next_rdata[7:0] = 8'h00;
							end
						end else if (wofs == vlan_acl_pkg::ACL_BEN_MSB_OFS) begin
							next_rdata = {24'h00_0000, aben[port_sel[2:0]][15:8]};
						end else if (wofs == vlan_acl_pkg::ACL_BEN_LSB_OFS) begin
							next_rdata = {24'h00_0000, aben[port_sel[2:0]][7:0]};
						end else if (wofs == vlan_acl_pkg::ACL_CTRL_OFS) begin
							next_rdata = {25'h000_0000, awr_done[port_sel[2:0]],
								ard_done[port_sel[2:0]], 1'b0, aidx[port_sel[2:0]]};
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_out <= 32'h0000_0000;
		end else begin
			rdata_out <= next_rdata;
		end
	end

	// Byte 10/11 and 14/15 layouts are stored raw; fields ride in fixed bit spots

	property p_vlan_selfclear;
		@(posedge clk_in) disable iff (!rst_b_in)
		(vstate == vlan_acl_pkg::VLAN_IDLE && wr_in && addr_in == vlan_acl_pkg::VLAN_CTRL_ADDR
			&& wdata_in[7]) |=> vstate == vlan_acl_pkg::VLAN_BUSY ##2
			vstate == vlan_acl_pkg::VLAN_IDLE;
	endproperty
	a_vlan_selfclear: assert property (p_vlan_selfclear) else $error("start not cleared");

	property p_acl_read_done;
		@(posedge clk_in) disable iff (!rst_b_in)
		(ctrl_wr[0] && !wdata_in[4]) |=> !ard_done[0] ##1 ard_done[0];
	endproperty
	a_acl_read_done: assert property (p_acl_read_done) else $error("rule read status");

	property p_fwd_mask;
		@(posedge clk_in) disable iff (!rst_b_in)
		!$past(look.use_member_list) |-> lookup_fwd_mask_out == 7'h00;
	endproperty
	a_fwd_mask: assert property (p_fwd_mask) else $error("mask without option");

	property p_rdata_zero;
		@(posedge clk_in) disable iff (!rst_b_in)
		!rd_in |=> rdata_out == 32'h0000_0000;
	endproperty
	a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside slot");

	property p_acl_write_done;
		@(posedge clk_in) disable iff (!rst_b_in)
		acl_do_wr[0] |=> awr_done[0];
	endproperty
	a_acl_write_done: assert property (p_acl_write_done) else $error("write status");

	property p_unused_byte;
		@(posedge clk_in) disable iff (!rst_b_in)
		(rd_in && in_win && wofs == 8'(vlan_acl_pkg::ACL_UNUSED_BYTE)) |=>
			rdata_out == 32'h0000_0000;
	endproperty
	a_unused_byte: assert property (p_unused_byte) else $error("unused byte");

	property p_rule_rsvd;
		@(posedge clk_in) disable iff (!rst_b_in)
		(rd_in && in_win && wofs == 8'h00) |=> rdata_out[7:4] == 4'h0;
	endproperty
	a_rule_rsvd: assert property (p_rule_rsvd) else $error("reserved bits");

	// Refused writes while busy keep the entry address steady
	property p_vlan_index_hold;
		@(posedge clk_in) disable iff (!rst_b_in)
		vstate == vlan_acl_pkg::VLAN_BUSY |=> vindex == $past(vindex);
	endproperty
	a_vlan_index_hold: assert property (p_vlan_index_hold) else $error("index moved");

	c_vlan_write: cover property (@(posedge clk_in) disable iff (!rst_b_in) vmem_we);
	c_vlan_read: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		vstate == vlan_acl_pkg::VLAN_BUSY && vread);
	c_acl_write: cover property (@(posedge clk_in) disable iff (!rst_b_in) |acl_do_wr);
	c_acl_read: cover property (@(posedge clk_in) disable iff (!rst_b_in) |ard_pend);
endmodule : vlan_acl_table_access
`default_nettype wire

// ===== verification/vlan_acl_table_access_bench.sv
// Bench for the VLAN and rule table access block: register tasks, lookup checks.
// Assumes read data one cycle after the strobe and polled completion flags.
`timescale 1ns/1ps
`default_nettype none
module vlan_acl_table_access_bench;
	logic        clk_in        = 1'b0;
	logic        rst_b_in      = 1'b0;
	logic [15:0] addr_in       = 16'h0000;
	logic [31:0] wdata_in      = 32'h0000_0000;
	logic        wr_in         = 1'b0;
	logic        rd_in         = 1'b0;
	logic [11:0] lookup_vid_in = 12'h000;
	logic [31:0] rdata_out;
	logic        lookup_valid_out;
	logic [6:0]  lookup_fwd_mask_out;
	logic [6:0]  lookup_untag_out;
	logic [2:0]  lookup_prio_out;
	logic [6:0]  lookup_filter_out;
	int          n_errors  = 0;
	int          tests_run = 0;
	int          cycles    = 0;
	logic [31:0] got;
	logic [7:0]  exp_b;

	vlan_acl_table_access vlan_acl_table_access_i (
		.clk_in              (clk_in),
		.rst_b_in            (rst_b_in),
		.addr_in             (addr_in),
		.wdata_in            (wdata_in),
		.wr_in               (wr_in),
		.rd_in               (rd_in),
		.lookup_vid_in       (lookup_vid_in),
		.rdata_out           (rdata_out),
		.lookup_valid_out    (lookup_valid_out),
		.lookup_fwd_mask_out (lookup_fwd_mask_out),
		.lookup_untag_out    (lookup_untag_out),
		.lookup_prio_out     (lookup_prio_out),
		.lookup_filter_out   (lookup_filter_out)
	);

	always #12.5 clk_in = ~clk_in;

	task automatic conclude();
		$display("errors %0d, comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	// Ceiling well above the roughly 250 cycles the sequence needs
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr_reg

	// Data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		d = rdata_out;
	endtask : rd_reg

	// Bounded poll; a flag that never settles counts as a mismatch
	task automatic poll(input logic [15:0] a, input int b, input logic lvl);
		int k;
		k = 0;
		rd_reg(a, got);
		while (got[b] !== lvl && k < 20) begin
			rd_reg(a, got);
			k++;
		end
		chk("status flag", {31'h0, lvl}, {31'h0, got[b]});
	endtask : poll

	function automatic logic [15:0] acl(input logic [3:0] port, input logic [7:0] ofs);
		return {port, vlan_acl_pkg::ACL_WIN_PAGE[3:0], ofs};
	endfunction : acl

	task automatic vlan_wr(input logic [11:0] vid, input logic [31:0] e0, input logic [6:0] e1,
			input logic [6:0] e2);
		wr_reg(vlan_acl_pkg::VLAN_ENTRY0_ADDR, e0);
		wr_reg(vlan_acl_pkg::VLAN_ENTRY1_ADDR, {25'h0, e1});
		wr_reg(vlan_acl_pkg::VLAN_ENTRY2_ADDR, {25'h0, e2});
		wr_reg(vlan_acl_pkg::VLAN_INDEX_ADDR, {20'h0, vid});
		wr_reg(vlan_acl_pkg::VLAN_CTRL_ADDR, 32'h0000_0080);
		poll(vlan_acl_pkg::VLAN_CTRL_ADDR, 7, 1'b0);
	endtask : vlan_wr

	task automatic lk(input logic [11:0] vid, input logic [31:0] exp, input logic [31:0] mask);
		@(posedge clk_in);
		lookup_vid_in <= vid;
		repeat (3) @(posedge clk_in);
		#1;
		chk("lookup", exp, mask & {7'h0, lookup_valid_out, lookup_fwd_mask_out,
			lookup_untag_out, lookup_prio_out, lookup_filter_out});
	endtask : lk

	task automatic acl_load(input logic [3:0] port, input logic [7:0] base);
		for (int i = 0; i < 16; i++) begin
			wr_reg(acl(port, 8'(i)), {24'h0, 8'(base + 8'(i))});
		end
	endtask : acl_load

	task automatic acl_ben(input logic [3:0] port, input logic [15:0] ben);
		wr_reg(acl(port, vlan_acl_pkg::ACL_BEN_MSB_OFS), {24'h0, ben[15:8]});
		wr_reg(acl(port, vlan_acl_pkg::ACL_BEN_LSB_OFS), {24'h0, ben[7:0]});
	endtask : acl_ben

	task automatic acl_go(input logic [3:0] port, input logic [7:0] ctrl, input int done_bit);
		wr_reg(acl(port, vlan_acl_pkg::ACL_CTRL_OFS), {24'h0, ctrl});
		poll(acl(port, vlan_acl_pkg::ACL_CTRL_OFS), done_bit, 1'b1);
	endtask : acl_go

	initial begin
		repeat (8) @(posedge clk_in);
		rst_b_in <= 1'b1;
		rd_reg(16'h0500, got);
		chk("unmapped", 32'h0000_0000, got);
		rd_reg(acl(4'h1, vlan_acl_pkg::ACL_CTRL_OFS), got);
		chk("rule status after reset", 32'h0000_0060, got & 32'h0000_007F);
		vlan_wr(12'hFFF, {1'b1, 1'b1, 3'd5, 3'd6, 17'h0, 7'h5A}, 7'h33, 7'h55);
		vlan_wr(12'h005, {1'b1, 1'b0, 3'd2, 3'd1, 17'h0, 7'h11}, 7'h7F, 7'h6A);
		vlan_wr(12'h006, {1'b0, 1'b1, 3'd7, 3'd7, 17'h0, 7'h7F}, 7'h7F, 7'h7F);
		lk(12'hFFF, {7'h0, 1'b1, 7'h55, 7'h33, 3'd5, 7'h5A}, 32'hFFFF_FFFF);
		lk(12'h005, {7'h0, 1'b1, 7'h00, 7'h7F, 3'd2, 7'h11}, 32'hFFFF_FFFF);
		lk(12'h006, 32'h0000_0000, 32'h01FE_0000);
		// Read op reloads the entry registers from entry FFF, replacing the last write to 006
		wr_reg(vlan_acl_pkg::VLAN_INDEX_ADDR, 32'h0000_0FFF);
		wr_reg(vlan_acl_pkg::VLAN_CTRL_ADDR, 32'h0000_0081);
		poll(vlan_acl_pkg::VLAN_CTRL_ADDR, 7, 1'b0);
		rd_reg(vlan_acl_pkg::VLAN_ENTRY0_ADDR, got);
		chk("vlan entry0", 32'hEE00_005A, got & 32'hFF00_007F);
		rd_reg(vlan_acl_pkg::VLAN_ENTRY1_ADDR, got);
		chk("vlan entry1", 32'h0000_0033, got & 32'h0000_007F);
		rd_reg(vlan_acl_pkg::VLAN_ENTRY2_ADDR, got);
		chk("vlan entry2", 32'h0000_0055, got & 32'h0000_007F);
		acl_ben(4'h1, 16'hFFFF);
		acl_load(4'h1, 8'h50);
		acl_go(4'h1, 8'h1F, vlan_acl_pkg::ACL_WR_DONE_BIT);
		acl_ben(4'h2, 16'hFFFF);
		acl_load(4'h2, 8'hA0);
		acl_go(4'h2, 8'h1F, vlan_acl_pkg::ACL_WR_DONE_BIT);
		// Partial write: only first and last bytes; bit 3 selects nothing
		acl_load(4'h1, 8'hC5);
		acl_ben(4'h1, 16'h8009);
		acl_go(4'h1, 8'h1F, vlan_acl_pkg::ACL_WR_DONE_BIT);
		acl_ben(4'h1, 16'hFFFF);
		acl_go(4'h1, 8'h0F, vlan_acl_pkg::ACL_RD_DONE_BIT);
		for (int i = 0; i < 16; i++) begin
			exp_b = 8'h50 + 8'(i);
			if (i == 0) exp_b = 8'h05;
			if (i == 15) exp_b = 8'hD4;
			if (i == 12) exp_b = 8'h00;
			if (i == 11) exp_b = exp_b & 8'hE0;
			rd_reg(acl(4'h1, 8'(i)), got);
			chk("rule byte", {24'h0, exp_b}, got);
		end
		acl_go(4'h2, 8'h0F, vlan_acl_pkg::ACL_RD_DONE_BIT);
		rd_reg(acl(4'h2, 8'h0E), got);
		chk("port two group high", 32'h0000_00AE, got);
		rd_reg(acl(4'h2, 8'h0F), got);
		chk("port two group low", 32'h0000_00AF, got);
		conclude();
	end
endmodule : vlan_acl_table_access_bench
`default_nettype wire
